/* File: src/right_port_bus_width_matcher.sv */
// Contract
// - Match low and size low select the full 36-bit long-word mode.
// - Long-word mode has no lane selection; every access covers the word.
// - Long-word mode moves all 36 bits in one access.
// - Endian select is ignored in long-word mode.
// - Match high and size low select 18-bit word mode.
// - Word mode carries data on lines 0 to 17 only.
// - Word mode, little endian: low half-word first, reads and writes.
// - Word mode, big endian: high half-word first.
// - Word mode needs at least two host cycles per memory word.
// - Sub-counter steps the lane multiplexer on every narrow transfer.
// - Narrow pieces land in their own portion of the addressed word.
// - Match high and size high select 9-bit byte mode.
// - Byte mode carries data on lines 0 to 8 only.
// - Byte mode, little endian: lowest byte lane first.
// - Byte mode, big endian: highest byte lane first.
// - Byte mode needs at least four host cycles per memory word.
// - Byte mode keeps lines 9 to 35 undriven.
// - Sub-counter counts up for little endian, down for big endian.
`timescale 1ns/1ps
`default_nettype none
module right_port_bus_width_matcher
(
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              sys_rst,
    // Width configuration pins
    input  wire logic                              widthMatchSelect,
    input  wire logic                              widthSizeSelect,
    input  wire logic                              endianOrderSelect,
    // Host access controls
    input  wire logic                              accessValid,
    input  wire logic                              writeSelect,
    input  wire logic                              countEnable,
    input  wire logic                              addrLoad,
    input  wire logic [bus_match_pkg::ADDR_W-1:0]  addrIn,
    // Right-port data pins
    input  wire logic [bus_match_pkg::DATA_W-1:0]  ioIn,
    output logic      [bus_match_pkg::DATA_W-1:0]  ioOut,
    output logic      [bus_match_pkg::DATA_W-1:0]  ioOe,
    // Memory array side
    output logic      [bus_match_pkg::ADDR_W-1:0]  memAddr,
    input  wire logic [bus_match_pkg::DATA_W-1:0]  memRdData,
    output logic                                   memWrEn,
    output logic      [bus_match_pkg::ADDR_W-1:0]  memWrAddr,
    output logic      [bus_match_pkg::LANE_CNT-1:0] memWrMask,
    output logic      [bus_match_pkg::DATA_W-1:0]  memWrData,
    // Status
    output logic                                   wordDone
);

    bus_match_pkg::width_mode_e             modeNext;
    bus_match_pkg::width_mode_e             mode_reg;
    logic                                   bigEndian_reg;
    logic                                   bigEndianNext;
    logic                                   cfgChanged;
    logic [bus_match_pkg::SUB_W-1:0]        subCount_reg;
    logic [bus_match_pkg::SUB_W-1:0]        startPos;
    logic [bus_match_pkg::SUB_W-1:0]        startNext;
    logic [bus_match_pkg::SUB_W-1:0]        lastPos;
    logic [bus_match_pkg::SUB_W-1:0]        widthLast;
    logic                                   pieceLast;
    logic                                   readCycle;
    logic                                   writeCycle;
    logic [bus_match_pkg::DATA_W-1:0]       oeFootprint;
    logic [bus_match_pkg::ADDR_W-1:0]       addr_reg;
    logic [bus_match_pkg::DATA_W-1:0]       ioOut_reg;
    logic [bus_match_pkg::DATA_W-1:0]       ioOe_reg;
    logic                                   memWrEn_reg;
    logic [bus_match_pkg::ADDR_W-1:0]       memWrAddr_reg;
    logic [bus_match_pkg::LANE_CNT-1:0]     memWrMask_reg;
    logic [bus_match_pkg::DATA_W-1:0]       memWrData_reg;
    logic                                   wordDone_reg;

    lane_steer_if steerBus ();

    lane_steer u_steer
    (
        .st (steerBus.steer)
    );

    // Mode decode from the width pins
    always_comb
    begin
        if (widthMatchSelect && widthSizeSelect)
        begin
            modeNext = bus_match_pkg::MODE_BYTE;
        end
        else if (widthMatchSelect)
        begin
            modeNext = bus_match_pkg::MODE_HALF;
        end
        else
        begin
            // Unlisted match-low/size-high combination falls back to full width
            modeNext = bus_match_pkg::MODE_LONG;
        end
    end

    // Endian order only matters in the narrow modes
    assign bigEndianNext = endianOrderSelect && (modeNext != bus_match_pkg::MODE_LONG);

    // Selects are sampled a cycle ahead of use; a change of decoded mode or endian order restarts the word
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            mode_reg      <= bus_match_pkg::MODE_LONG;
            bigEndian_reg <= 1'b0;
        end
        else
        begin
            mode_reg      <= modeNext;
            bigEndian_reg <= bigEndianNext;
        end
    end

    assign cfgChanged = (modeNext != mode_reg) || (bigEndianNext != bigEndian_reg);

    // Sub-counter bounds per width and order
    always_comb
    begin
        widthLast = bus_match_pkg::SUB_FIRST;
        if (mode_reg == bus_match_pkg::MODE_HALF)
        begin
            widthLast = bus_match_pkg::HALF_LAST;
        end
        else if (mode_reg == bus_match_pkg::MODE_BYTE)
        begin
            widthLast = bus_match_pkg::BYTE_LAST;
        end
    end

    assign startPos  = bigEndian_reg ? widthLast : bus_match_pkg::SUB_FIRST;
    assign lastPos   = bigEndian_reg ? bus_match_pkg::SUB_FIRST : widthLast;
    assign pieceLast = (subCount_reg == lastPos);
    // Start of the incoming config; the registered one is stale on a change
    assign startNext = !bigEndianNext ? bus_match_pkg::SUB_FIRST
                     : (modeNext == bus_match_pkg::MODE_BYTE) ? bus_match_pkg::BYTE_LAST
                     : bus_match_pkg::HALF_LAST;

    assign readCycle  = accessValid && !writeSelect && !cfgChanged;
    assign writeCycle = accessValid && writeSelect && !cfgChanged;

    // Sub-counter steering the lane multiplexer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            subCount_reg <= bus_match_pkg::SUB_FIRST;
        end
        else if (cfgChanged || addrLoad)
        begin
            subCount_reg <= cfgChanged ? startNext : startPos;
        end
        else if (readCycle || writeCycle)
        begin
            if (pieceLast)
            begin
                subCount_reg <= startPos;
            end
            else if (bigEndian_reg)
            begin
                subCount_reg <= subCount_reg - bus_match_pkg::SUB_STEP;
            end
            else
            begin
                subCount_reg <= subCount_reg + bus_match_pkg::SUB_STEP;
            end
        end
    end

    // Word address counter; it only moves once a whole word has passed
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            addr_reg <= bus_match_pkg::ADDR_RST;
        end
        else if (addrLoad)
        begin
            addr_reg <= addrIn;
        end
        else if ((readCycle || writeCycle) && pieceLast && countEnable)
        begin
            addr_reg <= addr_reg + bus_match_pkg::ADDR_ONE;
        end
    end

    // Lane steering hookup
    assign steerBus.mode     = mode_reg;
    assign steerBus.subCount = subCount_reg;
    assign steerBus.hostData = ioIn;
    assign steerBus.memWord  = memRdData;

    // Narrow widths leave the upper lines undriven
    always_comb
    begin
        oeFootprint = bus_match_pkg::OE_LONG;
        if (mode_reg == bus_match_pkg::MODE_HALF)
        begin
            oeFootprint = bus_match_pkg::OE_HALF;
        end
        else if (mode_reg == bus_match_pkg::MODE_BYTE)
        begin
            oeFootprint = bus_match_pkg::OE_BYTE;
        end
    end

    // Read path: one piece per access, registered onto the pins
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ioOut_reg <= bus_match_pkg::DATA_RST;
            ioOe_reg  <= bus_match_pkg::OE_NONE;
        end
        else if (readCycle)
        begin
            ioOut_reg <= steerBus.rdPiece;
            ioOe_reg  <= oeFootprint;
        end
        else
        begin
            ioOe_reg  <= bus_match_pkg::OE_NONE;
        end
    end

    // Write path: lane mask keeps the other portions of the word intact
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            memWrEn_reg   <= 1'b0;
            memWrAddr_reg <= bus_match_pkg::ADDR_RST;
            memWrMask_reg <= '0;
            memWrData_reg <= bus_match_pkg::DATA_RST;
        end
        else
        begin
            memWrEn_reg <= writeCycle;
            if (writeCycle)
            begin
                memWrAddr_reg <= addr_reg;
                memWrMask_reg <= steerBus.laneMask;
                memWrData_reg <= steerBus.wrWord;
            end
        end
    end

    // Word completion pulse
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wordDone_reg <= 1'b0;
        end
        else
        begin
            wordDone_reg <= (readCycle || writeCycle) && pieceLast;
        end
    end

    assign ioOut     = ioOut_reg;
    assign ioOe      = ioOe_reg;
    assign memAddr   = addr_reg;
    assign memWrEn   = memWrEn_reg;
    assign memWrAddr = memWrAddr_reg;
    assign memWrMask = memWrMask_reg;
    assign memWrData = memWrData_reg;
    assign wordDone  = wordDone_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic steady;
    assign steady = !cfgChanged && !addrLoad;

    sequence s_piece;
        (readCycle || writeCycle) && steady;
    endsequence

    sequence s_half_word;
        (s_piece and (mode_reg == bus_match_pkg::MODE_HALF && subCount_reg == startPos))
        ##1 s_piece;
    endsequence

    sequence s_byte_word;
        (s_piece and (mode_reg == bus_match_pkg::MODE_BYTE && subCount_reg == startPos))
        ##1 s_piece [*3];
    endsequence

    a_byte_hiz_upper : assert property (
        mode_reg == bus_match_pkg::MODE_BYTE && $past(mode_reg) == bus_match_pkg::MODE_BYTE
        |-> ioOe[35:9] == 27'h000_0000)
        else $error("byte mode drives upper lines");

    a_half_lines_only : assert property (
        mode_reg == bus_match_pkg::MODE_HALF && $past(mode_reg) == bus_match_pkg::MODE_HALF
        |-> ioOe[35:18] == 18'h0_0000)
        else $error("word mode drives upper half");

    a_long_full_read : assert property (
        readCycle && mode_reg == bus_match_pkg::MODE_LONG
        |=> ioOe == 36'hF_FFFF_FFFF && ioOut == $past(memRdData))
        else $error("long read not full width");

    a_long_no_endian : assert property (
        (s_piece and (mode_reg == bus_match_pkg::MODE_LONG && !cfgChanged))
        |=> subCount_reg == 2'h0 && $past(pieceLast))
        else $error("long mode sub-counter moved");

    a_sub_count_up : assert property (
        (s_piece and (!bigEndian_reg && !pieceLast))
        |=> subCount_reg == $past(subCount_reg) + 2'h1)
        else $error("little endian did not count up");

    a_sub_count_down : assert property (
        (s_piece and (bigEndian_reg && !pieceLast))
        |=> subCount_reg == $past(subCount_reg) - 2'h1)
        else $error("big endian did not count down");

    a_word_wrap_adv : assert property (
        (s_piece and (pieceLast && countEnable))
        |=> addr_reg == $past(addr_reg) + 15'h0001 && subCount_reg == $past(startPos))
        else $error("no wrap or address advance");

    a_half_two_cyc : assert property (
        s_half_word |=> wordDone && !$past(wordDone))
        else $error("word mode word not two pieces");

    a_byte_four_cyc : assert property (
        s_byte_word |=> wordDone ##1 1'b1)
        else $error("byte mode word not four pieces");

    a_byte_write_lane : assert property (
        writeCycle && mode_reg == bus_match_pkg::MODE_BYTE && subCount_reg == 2'h2
        |=> memWrMask == 4'h4 && memWrData[26:18] == $past(ioIn[8:0]))
        else $error("byte write in wrong lane");

    a_half_read_hi : assert property (
        readCycle && mode_reg == bus_match_pkg::MODE_HALF && subCount_reg == 2'h1
        |=> ioOut[17:0] == $past(memRdData[35:18]) && ioOut[35:18] == 18'h0_0000)
        else $error("upper half-word not on low lines");

    a_byte_big_first : assert property (
        (s_piece and (readCycle && mode_reg == bus_match_pkg::MODE_BYTE && bigEndian_reg
        && subCount_reg == startPos)) |=> ioOut[8:0] == $past(memRdData[35:27]))
        else $error("big endian byte start not top lane");

endmodule // right_port_bus_width_matcher
`default_nettype wire

/* File: src/bus_match_pkg.sv */
package bus_match_pkg;

    // Port geometry
    localparam int DATA_W   = 36;
    localparam int LANE_W   = 9;
    localparam int LANE_CNT = 4;
    localparam int HALF_W   = 18;
    localparam int ADDR_W   = 15;
    localparam int SUB_W    = 2;

    // Sub-counter positions
    localparam logic [SUB_W-1:0] SUB_FIRST = 2'h0;
    localparam logic [SUB_W-1:0] HALF_LAST = 2'h1;
    localparam logic [SUB_W-1:0] BYTE_LAST = 2'h3;
    localparam logic [SUB_W-1:0] SUB_STEP  = 2'h1;

    // Reset values and address step
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;

    // Output enable footprints per width
    localparam logic [DATA_W-1:0] OE_LONG = 36'hF_FFFF_FFFF;
    localparam logic [DATA_W-1:0] OE_HALF = 36'h0_0003_FFFF;
    localparam logic [DATA_W-1:0] OE_BYTE = 36'h0_0000_01FF;
    localparam logic [DATA_W-1:0] OE_NONE = 36'h0_0000_0000;

    // Right-port width modes
    typedef enum logic [2:0]
    {
        MODE_LONG = 3'h1,
        MODE_HALF = 3'h2,
        MODE_BYTE = 3'h4
    } width_mode_e;

endpackage

/* File: src/lane_steer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lane_steer_if;
    bus_match_pkg::width_mode_e                mode;
    logic [bus_match_pkg::SUB_W-1:0]           subCount;
    logic [bus_match_pkg::DATA_W-1:0]          hostData;
    logic [bus_match_pkg::DATA_W-1:0]          memWord;
    logic [bus_match_pkg::LANE_CNT-1:0]        laneMask;
    logic [bus_match_pkg::DATA_W-1:0]          wrWord;
    logic [bus_match_pkg::DATA_W-1:0]          rdPiece;

    modport steer
    (
        input  mode,
        input  subCount,
        input  hostData,
        input  memWord,
        output laneMask,
        output wrWord,
        output rdPiece
    );

    modport ctrl
    (
        output mode,
        output subCount,
        output hostData,
        output memWord,
        input  laneMask,
        input  wrWord,
        input  rdPiece
    );
endinterface
`default_nettype wire

/* File: src/lane_steer.sv */
`timescale 1ns/1ps
`default_nettype none
module lane_steer
(
    // Control side
    lane_steer_if.steer st
);
    localparam int LW = bus_match_pkg::LANE_W;

    logic [LW-1:0] memLane [bus_match_pkg::LANE_CNT];

    // Lane g of the 36-bit word is bits g*9 .. g*9+8
    genvar g;
    generate
        for (g = 0; g < bus_match_pkg::LANE_CNT; g++)
        begin : g_lane
            localparam logic [1:0] LANE_ID = 2'(g);
            localparam logic       HALF_ID = 1'(g / 2);
            localparam logic       IN_HALF = 1'(g % 2);

            assign memLane[g] = st.memWord[g*LW +: LW];

            always_comb
            begin
                st.laneMask[g]          = 1'b1;
                st.wrWord[g*LW +: LW]   = st.hostData[g*LW +: LW];
                st.rdPiece[g*LW +: LW]  = st.memWord[g*LW +: LW];
                if (st.mode == bus_match_pkg::MODE_HALF)
                begin
                    st.laneMask[g]         = (st.subCount[0] == HALF_ID);
                    st.wrWord[g*LW +: LW]  = st.hostData[IN_HALF*LW +: LW];
                    st.rdPiece[g*LW +: LW] = (g < 2) ?
                        memLane[{st.subCount[0], IN_HALF}] : '0;
                end
                else if (st.mode == bus_match_pkg::MODE_BYTE)
                begin
                    st.laneMask[g]         = (st.subCount == LANE_ID);
                    st.wrWord[g*LW +: LW]  = st.hostData[LW-1:0];
                    st.rdPiece[g*LW +: LW] = (g == 0) ? memLane[st.subCount] : '0;
                end
            end
        end
    endgenerate
endmodule // lane_steer
`default_nettype wire

/* File: dv/host_port_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_port_model
(
    // Clock
    input  wire logic                            clock,
    // Width configuration pins
    output logic                                 widthMatchSelect,
    output logic                                 widthSizeSelect,
    output logic                                 endianOrderSelect,
    // Access controls
    output logic                                 accessValid,
    output logic                                 writeSelect,
    output logic                                 countEnable,
    output logic                                 addrLoad,
    output logic [bus_match_pkg::ADDR_W-1:0]     addrIn,
    output logic [bus_match_pkg::DATA_W-1:0]     ioIn
);
    initial
    begin
        widthMatchSelect  = 1'h0;
        widthSizeSelect   = 1'h0;
        endianOrderSelect = 1'h0;
        accessValid       = 1'h0;
        writeSelect       = 1'h0;
        countEnable       = 1'h0;
        addrLoad          = 1'h0;
        addrIn            = 15'h0000;
        ioIn              = 36'h0_0000_0000;
    end

    // Pins settle two edges before any access relies on them
    task automatic setConfig(input logic m, input logic s, input logic e);
        @(posedge clock);
        accessValid       <= 1'h0;
        widthMatchSelect  <= m;
        widthSizeSelect   <= s;
        endianOrderSelect <= e;
        repeat (2) @(posedge clock);
    endtask

    task automatic loadAddr(input logic [bus_match_pkg::ADDR_W-1:0] a);
        @(posedge clock);
        accessValid <= 1'h0;
        addrLoad    <= 1'h1;
        addrIn      <= a;
        @(posedge clock);
        addrLoad    <= 1'h0;
        addrIn      <= ~a;
    endtask

    // One piece per cycle; the caller supplies every cycle of a word
    task automatic xfer(input logic wr, input logic [bus_match_pkg::DATA_W-1:0] d,
                        input logic ce);
        @(posedge clock);
        accessValid <= 1'h1;
        writeSelect <= wr;
        ioIn        <= d;
        countEnable <= ce;
    endtask

    // Released data lines toggle so stale values never look valid
    task automatic idle();
        @(posedge clock);
        accessValid <= 1'h0;
        ioIn        <= ~ioIn;
    endtask
endmodule // host_port_model
`default_nettype wire

/* File: dv/test_right_port_bus_width_matcher.sv */
`timescale 1ns/1ps
`default_nettype none
module test_right_port_bus_width_matcher;
    typedef struct {logic wr; logic [14:0] addr; logic [3:0] mask;
                    logic [35:0] data; logic [35:0] oe; logic done;} note_s;

    logic        clock;
    logic        sys_rst;
    logic        widthMatchSelect, widthSizeSelect, endianOrderSelect;
    logic        accessValid, writeSelect, countEnable, addrLoad;
    logic [14:0] addrIn, memAddr, memWrAddr, curAddr;
    logic [35:0] ioIn, ioOut, ioOe, memRdData, memWrData;
    logic        memWrEn, wordDone;
    logic [3:0]  memWrMask;
    logic [35:0] mem [32];
    logic [31:0] rndState;
    int          badCount, checksDone;
    note_s       noteQ[$];

    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    host_port_model hp_u (.clock(clock), .widthMatchSelect(widthMatchSelect),
        .widthSizeSelect(widthSizeSelect), .endianOrderSelect(endianOrderSelect),
        .accessValid(accessValid), .writeSelect(writeSelect), .countEnable(countEnable),
        .addrLoad(addrLoad), .addrIn(addrIn), .ioIn(ioIn));

    right_port_bus_width_matcher dut_u (.clock(clock), .sys_rst(sys_rst),
        .widthMatchSelect(widthMatchSelect), .widthSizeSelect(widthSizeSelect),
        .endianOrderSelect(endianOrderSelect), .accessValid(accessValid),
        .writeSelect(writeSelect), .countEnable(countEnable), .addrLoad(addrLoad),
        .addrIn(addrIn), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .memAddr(memAddr),
        .memRdData(memRdData), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
        .memWrMask(memWrMask), .memWrData(memWrData), .wordDone(wordDone));

    // Combinational array, as the design expects
    assign memRdData = mem[memAddr[4:0]];

    function automatic logic [35:0] laneBits(input logic [3:0] m);
        logic [35:0] r;
        r = 36'h0_0000_0000;
        for (int g = 0; g < 4; g++)
            if (m[g]) r[g*9 +: 9] = 9'h1FF;
        return r;
    endfunction

    always @(posedge clock)
    begin
        if (memWrEn === 1'h1)
            mem[memWrAddr[4:0]] <= (mem[memWrAddr[4:0]] & ~laneBits(memWrMask))
                                   | (memWrData & laneBits(memWrMask));
    end

    function automatic logic [31:0] rnd();
        rndState = rndState ^ (rndState << 13);
        rndState = rndState ^ (rndState >> 17);
        rndState = rndState ^ (rndState << 5);
        return rndState;
    endfunction

    task automatic fail(input string msg);
        $display("Error at %0t: %s", $time, msg);
        badCount++;
    endtask

    task automatic testDone();
        $display("Checks %0d, mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Result watcher: every design response takes the oldest note
    always @(posedge clock)
    begin
        note_s e;
        if (!sys_rst && (memWrEn === 1'h1 || ioOe !== 36'h0_0000_0000))
        begin
            checksDone++;
            if (noteQ.size() == 0)
                fail("unexpected response");
            else
            begin
                e = noteQ.pop_front();
                if (e.wr && (memWrEn !== 1'h1 || memWrAddr !== e.addr
                    || memWrMask !== e.mask || ioOe !== 36'h0_0000_0000
                    || (memWrData & laneBits(e.mask)) !== e.data))
                    fail("write piece wrong");
                if (!e.wr && (ioOut !== e.data || ioOe !== e.oe
                    || memWrEn !== 1'h0))
                    fail("read piece wrong");
                if (wordDone !== e.done)
                    fail("word completion wrong");
            end
        end
    end

    // The first pieces of one n-piece memory word, in endian order
    task automatic doWord(input int n, input logic be, input logic wr,
                          input logic [35:0] w, input logic ce, input int pieces);
        note_s e;
        int    lane;
        int    pw;
        for (int i = 0; i < pieces; i++)
        begin
            lane   = be ? n - 1 - i : i;
            pw     = 36 / n;
            e.mask = (n == 1) ? 4'hF : (n == 2) ? (lane ? 4'hC : 4'h3) : 4'h1 << lane;
            e.wr   = wr;
            e.addr = curAddr;
            e.done = (i == n - 1);
            e.oe   = (n == 1) ? bus_match_pkg::OE_LONG
                   : (n == 2) ? bus_match_pkg::OE_HALF : bus_match_pkg::OE_BYTE;
            e.data = wr ? (w & laneBits(e.mask)) : (w & laneBits(e.mask)) >> (lane * pw);
            noteQ.push_back(e);
            hp_u.xfer(wr, wr ? e.data >> (lane * pw) : {rnd(), 4'h5}, ce);
        end
        if (ce && pieces == n)
            curAddr = curAddr + 15'h0001;
    endtask

    task automatic drain();
        int k;
        hp_u.idle();
        for (k = 0; k < 20 && noteQ.size() != 0; k++)
            @(posedge clock);
        if (noteQ.size() != 0)
            fail("responses missing");
    endtask

    initial
    begin
        logic [35:0] w0, w1, w2;
        int          n;
        logic        be;
        sys_rst  = 1'h1;
        rndState = 32'h0000_345D;
        badCount = 0;
        checksDone = 0;
        curAddr  = 15'h0000;
        for (int a = 0; a < 32; a++)
            mem[a] = 36'h0_0000_0000;
        repeat (4) @(posedge clock);
        sys_rst <= 1'h0;
        for (int cfg = 0; cfg < 6; cfg++)
        begin
            n  = (cfg < 2) ? 1 : (cfg < 4) ? 2 : 4;
            be = cfg[0];
            hp_u.setConfig(n != 1, n == 4 || cfg == 1, be);
            if (n > 1)
                doWord(n, be, 1'h1, {rnd(), 4'hA}, 1'h1, 1);
            hp_u.loadAddr(15'(cfg * 4));
            curAddr = 15'(cfg * 4);
            w0 = 36'({rnd(), rnd()});
            w1 = 36'({rnd(), rnd()});
            w2 = 36'({rnd(), rnd()});
            doWord(n, be, 1'h1, w0, 1'h1, n);
            doWord(n, be, 1'h1, w1, 1'h0, n);
            doWord(n, be, 1'h1, w2, 1'h1, n);
            drain();
            hp_u.loadAddr(15'(cfg * 4));
            curAddr = 15'(cfg * 4);
            doWord(n, be, 1'h0, w0, 1'h1, n);
            doWord(n, be, 1'h0, w2, 1'h1, n);
            drain();
            $display("Test width %0d endian %0d done, mismatches %0d", 36 / n, be, badCount);
        end
        testDone();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        fail("run did not finish");
        testDone();
    end
endmodule // test_right_port_bus_width_matcher
`default_nettype wire
